// ===== rtl/acp_defs.vh
`ifndef ACP_DEFS_VH
`define ACP_DEFS_VH

`define ACP_OFS_RESET          8'h01
`define ACP_OFS_CODEC_SRC      8'h04
`define ACP_OFS_PLL_PRE        8'h05
`define ACP_OFS_PLL_INT        8'h06
`define ACP_OFS_PLL_FRAC_HI    8'h07
`define ACP_OFS_PLL_FRAC_LO    8'h08
`define ACP_OFS_DIV1           8'h0b
`define ACP_OFS_DIV2           8'h0c
`define ACP_OFS_OSR_HI         8'h0d
`define ACP_OFS_OSR_LO         8'h0e
`define ACP_OFS_IF_CTRL        8'h1b
`define ACP_OFS_CKO_SRC        8'h19
`define ACP_OFS_CKO_DIV        8'h1a
`define ACP_OFS_BCK_SRC        8'h1d
`define ACP_OFS_BCK_DIV        8'h1e
`define ACP_OFS_PWR_FLAGS      8'h25
`define ACP_OFS_CHAN_PWR       8'h3f

`define ACP_RST_CODEC_SRC      8'h00
`define ACP_RST_PLL_PRE        8'h11
`define ACP_RST_PLL_INT        8'h04
`define ACP_RST_FRAC           8'h00
`define ACP_RST_DIV            8'h01
`define ACP_RST_OSR_HI         8'h00
`define ACP_RST_OSR_LO         8'h80
`define ACP_RST_MUX            8'h00
`define ACP_RST_OUT_DIV        8'h01

`define ACP_BIT_PWR            7
`define ACP_BIT_BCK_DRIVE      3
`define ACP_BIT_LEFT_UP        7
`define ACP_BIT_RIGHT_UP       3
`define ACP_BIT_CHAN_L         7
`define ACP_BIT_CHAN_R         6

`define ACP_SHUTDOWN_CYCLES    16'd64

`endif

// ===== rtl/acp_clk_div.v
`timescale 1ns/100ps
// Divides by a 7-bit value, zero meaning 128; emits a one-cycle enable per output tick
module acp_clk_div #(
	parameter W = 7
) (
	clk,
	reset,
	run,
	tick_in,
	div_val,
	tick_out,
	level_out
);
	input  wire         clk;
	input  wire         reset;
	input  wire         run;
	input  wire         tick_in;
	input  wire [W-1:0] div_val;
	output reg          tick_out;
	output reg          level_out;

	reg  [W:0] cnt_reg;
	wire [W:0] limit;
	wire       wrap;
	wire [W:0] cnt_next;

	assign limit = (div_val == {W{1'b0}}) ? {1'b1, {W{1'b0}}} : {1'b0, div_val};
	// A count left above a newly lowered limit wraps at once
	assign wrap     = (cnt_reg + 1'b1 >= limit);
	assign cnt_next = wrap ? {(W+1){1'b0}} : cnt_reg + 1'b1;

	always @(posedge clk) begin
		if (reset || !run) begin
			cnt_reg   <= {(W+1){1'b0}};
			tick_out  <= 1'b0;
			level_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				cnt_reg  <= cnt_next;
				tick_out <= wrap;
				// High from the wrap for half a period, so it rises once per period even when dividing by two
				level_out <= (cnt_next < (limit >> 1)) || (limit == {{W{1'b0}}, 1'b1} && !level_out);
			end
		end
	end
endmodule // acp_clk_div

// ===== rtl/acp_pll.v
`timescale 1ns/100ps
// Behavioural fractional PLL: phase accumulator in units of 1/10000 of an input tick
module acp_pll (
	clk,
	reset,
	enable,
	tick_in,
	pre_div,
	post_mul,
	int_mul,
	frac,
	tick_out
);
	input  wire        clk;
	input  wire        reset;
	input  wire        enable;
	input  wire        tick_in;
	input  wire [2:0]  pre_div;
	input  wire [3:0]  post_mul;
	input  wire [5:0]  int_mul;
	input  wire [13:0] frac;
	output reg         tick_out;

	reg  [31:0] acc_reg;
	wire [4:0]  r_val;
	wire [3:0]  p_val;
	wire [31:0] step;
	wire [31:0] wrap;

	// Zero codes stand for the top of each range
	assign r_val = (post_mul == 4'h0) ? 5'h10 : {1'b0, post_mul};
	assign p_val = (pre_div == 3'h0) ? 4'h8 : {1'b0, pre_div};
	// Output rate = input * R * (J + D/10000) / P
	assign step = (({26'h0, int_mul} * 32'd10000) + {18'h0, frac}) * {27'h0, r_val};
	assign wrap = {28'h0, p_val} * 32'd10000;

	always @(posedge clk) begin
		if (reset || !enable) begin
			acc_reg  <= 32'h0;
			tick_out <= 1'b0;
		end else begin
			// Output limited to one tick per system clock; faster settings saturate
			if (acc_reg >= wrap) begin
				acc_reg  <= acc_reg - wrap + (tick_in ? step : 32'h0);
				tick_out <= 1'b1;
			end else begin
				acc_reg  <= acc_reg + (tick_in ? step : 32'h0);
				tick_out <= 1'b0;
			end
		end
	end
endmodule // acp_pll

// ===== rtl/acp_clock_tree.v
`timescale 1ns/100ps
`include "acp_defs.vh"
module acp_clock_tree #(
	parameter SHUTDOWN_CYCLES = 64
) (
	clk,
	reset,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	mclk_tick,
	bclk_in_tick,
	gp_in_tick,
	bclk_out,
	bclk_oe_n,
	gp_out,
	gp_oe_n,
	mod_clk_tick,
	sample_tick
);
	input  wire       clk;
	input  wire       reset;
	input  wire [7:0] reg_addr;
	input  wire [7:0] reg_wdata;
	input  wire       reg_wr;
	input  wire       reg_rd;
	output reg  [7:0] reg_rdata;
	input  wire       mclk_tick;
	input  wire       bclk_in_tick;
	input  wire       gp_in_tick;
	output wire       bclk_out;
	output wire       bclk_oe_n;
	output wire       gp_out;
	output wire       gp_oe_n;
	output wire       mod_clk_tick;
	output reg        sample_tick;

	reg  [7:0]  codec_clock_source_select_reg;
	reg  [7:0]  pll_enable_and_predivide_reg;
	reg  [7:0]  pll_integer_multiplier_reg;
	reg  [7:0]  pll_fraction_upper_reg;
	reg  [7:0]  pll_fraction_lower_reg;
	reg  [13:0] frac_active_reg;
	reg  [7:0]  first_divider_ctrl_reg;
	reg  [7:0]  second_divider_ctrl_reg;
	reg  [7:0]  oversample_ratio_upper_reg;
	reg  [7:0]  oversample_ratio_lower_reg;
	reg  [7:0]  iface_ctrl_reg;
	reg  [7:0]  clock_out_source_select_reg;
	reg  [7:0]  clock_out_divider_reg;
	reg  [7:0]  bit_clock_source_select_reg;
	reg  [7:0]  bit_clock_divider_reg;
	reg  [1:0]  chan_req_reg;
	reg         left_up_reg;
	reg         right_up_reg;
	reg  [15:0] seq_cnt_reg;
	reg  [9:0]  osr_cnt_reg;
	reg         codec_tick;
	reg         cko_in_tick;
	wire        soft_reset;
	wire        pll_tick;
	wire        div1_tick;
	wire        proc_tick;
	wire        bck_in_tick;
	wire [9:0]  osr_limit;
	wire        osr_wrap;
	wire        chan_on;

	assign soft_reset = reg_wr && reg_addr == `ACP_OFS_RESET && reg_wdata[0];

	always @(posedge clk) begin
		if (reset || soft_reset) begin
			codec_clock_source_select_reg <= `ACP_RST_CODEC_SRC;
			pll_enable_and_predivide_reg  <= `ACP_RST_PLL_PRE;
			pll_integer_multiplier_reg    <= `ACP_RST_PLL_INT;
			pll_fraction_upper_reg        <= `ACP_RST_FRAC;
			pll_fraction_lower_reg        <= `ACP_RST_FRAC;
			frac_active_reg               <= 14'h0;
			first_divider_ctrl_reg        <= `ACP_RST_DIV;
			second_divider_ctrl_reg       <= `ACP_RST_DIV;
			oversample_ratio_upper_reg    <= `ACP_RST_OSR_HI;
			oversample_ratio_lower_reg    <= `ACP_RST_OSR_LO;
			iface_ctrl_reg                <= `ACP_RST_MUX;
			clock_out_source_select_reg   <= `ACP_RST_MUX;
			clock_out_divider_reg         <= `ACP_RST_OUT_DIV;
			bit_clock_source_select_reg   <= `ACP_RST_MUX;
			bit_clock_divider_reg         <= `ACP_RST_OUT_DIV;
			chan_req_reg                  <= 2'b00;
		end else if (reg_wr) begin
			case (reg_addr)
				`ACP_OFS_CODEC_SRC:   codec_clock_source_select_reg <= {6'h0, reg_wdata[1:0]};
				`ACP_OFS_PLL_PRE:     pll_enable_and_predivide_reg  <= reg_wdata;
				`ACP_OFS_PLL_INT:     pll_integer_multiplier_reg    <= {2'b00, reg_wdata[5:0]};
				`ACP_OFS_PLL_FRAC_HI: pll_fraction_upper_reg        <= {2'b00, reg_wdata[5:0]};
				`ACP_OFS_PLL_FRAC_LO: begin
					pll_fraction_lower_reg <= reg_wdata;
					// Fraction only moves as a whole on the low byte write
					frac_active_reg <= {pll_fraction_upper_reg[5:0], reg_wdata};
				end
				`ACP_OFS_DIV1:        first_divider_ctrl_reg      <= reg_wdata;
				`ACP_OFS_DIV2:        second_divider_ctrl_reg     <= reg_wdata;
				`ACP_OFS_OSR_HI:      oversample_ratio_upper_reg  <= {6'h0, reg_wdata[1:0]};
				`ACP_OFS_OSR_LO:      oversample_ratio_lower_reg  <= reg_wdata;
				`ACP_OFS_IF_CTRL:     iface_ctrl_reg              <= reg_wdata;
				`ACP_OFS_CKO_SRC:     clock_out_source_select_reg <= {5'h0, reg_wdata[2:0]};
				`ACP_OFS_CKO_DIV:     clock_out_divider_reg       <= reg_wdata;
				`ACP_OFS_BCK_SRC:     bit_clock_source_select_reg <= {6'h0, reg_wdata[1:0]};
				`ACP_OFS_BCK_DIV:     bit_clock_divider_reg       <= reg_wdata;
				`ACP_OFS_CHAN_PWR:    chan_req_reg <= {reg_wdata[`ACP_BIT_CHAN_L], reg_wdata[`ACP_BIT_CHAN_R]};
				default: ;
			endcase
		end
	end

	always @* begin
		case (reg_addr)
			`ACP_OFS_CODEC_SRC:   reg_rdata = codec_clock_source_select_reg;
			`ACP_OFS_PLL_PRE:     reg_rdata = pll_enable_and_predivide_reg;
			`ACP_OFS_PLL_INT:     reg_rdata = pll_integer_multiplier_reg;
			`ACP_OFS_PLL_FRAC_HI: reg_rdata = pll_fraction_upper_reg;
			`ACP_OFS_PLL_FRAC_LO: reg_rdata = pll_fraction_lower_reg;
			`ACP_OFS_DIV1:        reg_rdata = first_divider_ctrl_reg;
			`ACP_OFS_DIV2:        reg_rdata = second_divider_ctrl_reg;
			`ACP_OFS_OSR_HI:      reg_rdata = oversample_ratio_upper_reg;
			`ACP_OFS_OSR_LO:      reg_rdata = oversample_ratio_lower_reg;
			`ACP_OFS_IF_CTRL:     reg_rdata = iface_ctrl_reg;
			`ACP_OFS_CKO_SRC:     reg_rdata = clock_out_source_select_reg;
			`ACP_OFS_CKO_DIV:     reg_rdata = clock_out_divider_reg;
			`ACP_OFS_BCK_SRC:     reg_rdata = bit_clock_source_select_reg;
			`ACP_OFS_BCK_DIV:     reg_rdata = bit_clock_divider_reg;
			`ACP_OFS_CHAN_PWR:    reg_rdata = {chan_req_reg[1], chan_req_reg[0], 6'h0};
			`ACP_OFS_PWR_FLAGS:   reg_rdata = {left_up_reg, 3'b000, right_up_reg, 3'b000};
			default:              reg_rdata = 8'h00;
		endcase
	end

	// Channel power state: up needs both dividers running; down holds until shutdown count expires
	assign chan_on = first_divider_ctrl_reg[`ACP_BIT_PWR] && second_divider_ctrl_reg[`ACP_BIT_PWR];

	always @(posedge clk) begin
		if (reset || soft_reset) begin
			left_up_reg  <= 1'b0;
			right_up_reg <= 1'b0;
			seq_cnt_reg  <= 16'h0;
		end else begin
			if (chan_req_reg != 2'b00 && chan_on) begin
				left_up_reg  <= left_up_reg | chan_req_reg[1];
				right_up_reg <= right_up_reg | chan_req_reg[0];
			end
			if ((left_up_reg && !chan_req_reg[1]) || (right_up_reg && !chan_req_reg[0])) begin
				// Shutdown stalls if software drops a divider early
				if (mod_clk_tick)
					seq_cnt_reg <= seq_cnt_reg + 16'h1;
				if (seq_cnt_reg >= SHUTDOWN_CYCLES[15:0] - 16'h1 && mod_clk_tick) begin
					seq_cnt_reg <= 16'h0;
					if (!chan_req_reg[1])
						left_up_reg <= 1'b0;
					if (!chan_req_reg[0])
						right_up_reg <= 1'b0;
				end
			end else begin
				seq_cnt_reg <= 16'h0;
			end
		end
	end

	acp_pll u_pll (
		.clk      (clk),
		.reset    (reset || soft_reset),
		.enable   (pll_enable_and_predivide_reg[`ACP_BIT_PWR]),
		.tick_in  (mclk_tick),
		.pre_div  (pll_enable_and_predivide_reg[6:4]),
		.post_mul (pll_enable_and_predivide_reg[3:0]),
		.int_mul  (pll_integer_multiplier_reg[5:0]),
		.frac     (frac_active_reg),
		.tick_out (pll_tick)
	);

	always @* begin
		case (codec_clock_source_select_reg[1:0])
			2'b00:   codec_tick = mclk_tick;
			2'b01:   codec_tick = bclk_in_tick;
			2'b10:   codec_tick = gp_in_tick;
			default: codec_tick = pll_tick;
		endcase
	end

	acp_clk_div u_div1 (
		.clk       (clk),
		.reset     (reset || soft_reset),
		.run       (first_divider_ctrl_reg[`ACP_BIT_PWR]),
		.tick_in   (codec_tick),
		.div_val   (first_divider_ctrl_reg[6:0]),
		.tick_out  (div1_tick),
		.level_out ()
	);

	// Processing clock is the first divider's output
	assign proc_tick = div1_tick;

	acp_clk_div u_div2 (
		.clk       (clk),
		.reset     (reset || soft_reset),
		.run       (second_divider_ctrl_reg[`ACP_BIT_PWR]),
		.tick_in   (div1_tick),
		.div_val   (second_divider_ctrl_reg[6:0]),
		.tick_out  (mod_clk_tick),
		.level_out ()
	);

	// Zero ratio treated as 1024, the field's full range
	assign osr_limit = {oversample_ratio_upper_reg[1:0], oversample_ratio_lower_reg};
	// A ratio cut below the running count wraps at once rather than after a full 1024-tick lap
	assign osr_wrap = (osr_cnt_reg + 10'h1 == osr_limit) || (osr_limit != 10'h0 && osr_cnt_reg >= osr_limit);

	always @(posedge clk) begin
		if (reset || soft_reset) begin
			osr_cnt_reg <= 10'h0;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= 1'b0;
			if (mod_clk_tick) begin
				if (osr_wrap) begin
					osr_cnt_reg <= 10'h0;
					sample_tick <= 1'b1;
				end else begin
					osr_cnt_reg <= osr_cnt_reg + 10'h1;
				end
			end
		end
	end

	assign bck_in_tick = bit_clock_source_select_reg[0] ? mod_clk_tick : proc_tick;

	// Free-running, so the bit clock phase is already settled when the pin drive is switched on
	acp_clk_div u_bck_div (
		.clk       (clk),
		.reset     (reset || soft_reset),
		.run       (1'b1),
		.tick_in   (bck_in_tick),
		.div_val   (bit_clock_divider_reg[6:0]),
		.tick_out  (),
		.level_out (bclk_out)
	);

	assign bclk_oe_n = ~iface_ctrl_reg[`ACP_BIT_BCK_DRIVE];

	always @* begin
		case (clock_out_source_select_reg[2:0])
			3'b000:  cko_in_tick = mclk_tick;
			3'b001:  cko_in_tick = bclk_in_tick;
			3'b010:  cko_in_tick = gp_in_tick;
			3'b011:  cko_in_tick = pll_tick;
			3'b100:  cko_in_tick = proc_tick;
			3'b101:  cko_in_tick = mod_clk_tick;
			default: cko_in_tick = 1'b0;
		endcase
	end

	acp_clk_div u_cko_div (
		.clk       (clk),
		.reset     (reset || soft_reset),
		.run       (clock_out_divider_reg[`ACP_BIT_PWR]),
		.tick_in   (cko_in_tick),
		.div_val   (clock_out_divider_reg[6:0]),
		.tick_out  (),
		.level_out (gp_out)
	);

	assign gp_oe_n = ~clock_out_divider_reg[`ACP_BIT_PWR];
endmodule // acp_clock_tree

// ===== sim/acp_clock_tree_assertions.sv
`timescale 1ns/100ps
module acp_clock_tree_assertions (
	input logic       clk,
	input logic       reset,
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic       reg_wr,
	input logic [7:0] reg_rdata,
	input logic       bclk_out,
	input logic       bclk_oe_n,
	input logic       gp_oe_n,
	input logic       mod_clk_tick,
	input logic       sample_tick
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Dividers leave reset unpowered and no write can land this early
	property p_rst_idle;
		$fell(reset) |-> (bclk_oe_n && gp_oe_n && !mod_clk_tick && !sample_tick) [*4];
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("clock outputs active after reset");
	property p_bck_drive;
		reg_wr && reg_addr == 8'h1b |=> bclk_oe_n == !$past(reg_wdata[3]);
	endproperty
	a_bck_drive: assert property (p_bck_drive) else $error("bit clock drive enable wrong");
	property p_gp_drive;
		reg_wr && reg_addr == 8'h1a |=> gp_oe_n == !$past(reg_wdata[7]);
	endproperty
	a_gp_drive: assert property (p_gp_drive) else $error("clock out drive enable wrong");
	property p_div_rb;
		reg_wr && reg_addr == 8'h0b ##1 reg_addr == 8'h0b |-> reg_rdata == $past(reg_wdata);
	endproperty
	a_div_rb: assert property (p_div_rb) else $error("divider readback wrong");
	property p_pre_rb;
		reg_wr && reg_addr == 8'h05 ##1 reg_addr == 8'h05 |-> reg_rdata == $past(reg_wdata);
	endproperty
	a_pre_rb: assert property (p_pre_rb) else $error("pll control readback wrong");
	property p_frac_rb;
		reg_wr && reg_addr == 8'h07 ##1 reg_addr == 8'h07 |-> reg_rdata == {2'b00, $past(reg_wdata[5:0])};
	endproperty
	a_frac_rb: assert property (p_frac_rb) else $error("fraction upper readback wrong");
	property p_soft_rst;
		reg_wr && reg_addr == 8'h01 && reg_wdata[0] ##1 reg_addr == 8'h05 |-> reg_rdata == 8'h11 && bclk_oe_n;
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("soft reset left state behind");
	property p_src_rsv;
		reg_addr == 8'h04 |-> reg_rdata[7:2] == 6'h00;
	endproperty
	a_src_rsv: assert property (p_src_rsv) else $error("source select reserved bits set");
	property p_flag_rsv;
		reg_addr == 8'h25 |-> (reg_rdata & 8'h77) == 8'h00;
	endproperty
	a_flag_rsv: assert property (p_flag_rsv) else $error("power flag reserved bits set");
	cover property (reg_wr && reg_addr == 8'h01 && reg_wdata[0]);
	cover property (sample_tick);
	cover property (!bclk_oe_n && $rose(bclk_out));
endmodule // acp_clock_tree_assertions

bind acp_clock_tree acp_clock_tree_assertions u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .bclk_out(bclk_out),
	.bclk_oe_n(bclk_oe_n), .gp_oe_n(gp_oe_n), .mod_clk_tick(mod_clk_tick), .sample_tick(sample_tick));

// ===== sim/acp_clock_tree_test.sv
`timescale 1ns/100ps
module acp_clock_tree_test;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        mclk_tick = 1'b0;
	logic        bclk_in_tick = 1'b0;
	logic        gp_in_tick = 1'b0;
	wire  [7:0]  reg_rdata;
	wire         bclk_out, bclk_oe_n, gp_out, gp_oe_n, mod_clk_tick, sample_tick;
	int          err_count = 0;
	int          samples_checked = 0;
	int          seed = 32'h7f540845;
	int          cnt[7] = '{default: 0};
	int          d[7];
	int          ge[7];
	int          i;
	logic        bq = 1'b0;
	logic        gq = 1'b0;
	logic [31:0] r;
	logic [7:0]  da[15] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h19, 8'h1a,
		8'h1d, 8'h1e, 8'h25, 8'h02};
	logic [7:0]  dv[15] = '{8'h00, 8'h11, 8'h04, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'h00, 8'h01,
		8'h00, 8'h01, 8'h00, 8'h00};

	acp_clock_tree #(.SHUTDOWN_CYCLES(4)) dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mclk_tick(mclk_tick), .bclk_in_tick(bclk_in_tick), .gp_in_tick(gp_in_tick), .bclk_out(bclk_out),
		.bclk_oe_n(bclk_oe_n), .gp_out(gp_out), .gp_oe_n(gp_oe_n), .mod_clk_tick(mod_clk_tick),
		.sample_tick(sample_tick));

	always #10 clk = ~clk;

	// Reference inputs tick at random rates 1/2, 1/4 and 1/8; counts index 0..6 are
	// master, bit, general, modulator, sample, bit clock out rises, clock out rises
	always @(posedge clk) begin
		r = $random(seed);
		mclk_tick <= r[0];
		bclk_in_tick <= &r[2:1];
		gp_in_tick <= &r[5:3];
		cnt[0] <= cnt[0] + mclk_tick;
		cnt[1] <= cnt[1] + bclk_in_tick;
		cnt[2] <= cnt[2] + gp_in_tick;
		cnt[3] <= cnt[3] + mod_clk_tick;
		cnt[4] <= cnt[4] + sample_tick;
		cnt[5] <= cnt[5] + (bclk_out & !bq);
		cnt[6] <= cnt[6] + (gp_out & !gq);
		bq <= bclk_out;
		gq <= gp_out;
	end

	// Rates are compared with a small slack since divider phase carries across changes
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
		samples_checked++;
		if (got !== exp && !(^got !== 1'bx && (got > exp ? got - exp : exp - got) <= tol)) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk(reg_rdata, e, 0);
		@(posedge clk);
	endtask

	task automatic meas(input int n);
		int s[7];
		s = cnt;
		repeat (n) @(posedge clk);
		@(negedge clk);
		foreach (d[k]) d[k] = cnt[k] - s[k];
		@(posedge clk);
	endtask

	task automatic dflt;
		for (int k = 0; k < 15; k++) rd(da[k], dv[k]);
	endtask

	function automatic int pexp(int n, int rr, int j, int dd, int p);
		return n * rr * (j * 10000 + dd) / (p * 10000);
	endfunction

	task automatic results;
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		results();
	end

	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		dflt();
		chk({bclk_oe_n, gp_oe_n}, 2'b11, 0);
		wr(8'h02, 8'hff);
		rd(8'h02, 8'h00);
		wr(8'h05, 8'h23);
		rd(8'h05, 8'h23);
		wr(8'h06, 8'hff);
		rd(8'h06, 8'h3f);
		wr(8'h07, 8'hff);
		rd(8'h07, 8'h3f);
		wr(8'h0b, 8'h82);
		rd(8'h0b, 8'h82);
		wr(8'h0c, 8'h83);
		wr(8'h0d, 8'h00);
		wr(8'h0e, 8'h04);
		for (i = 0; i < 3; i++) begin
			wr(8'h04, i[7:0]);
			rd(8'h04, i[7:0]);
			meas(1200);
			chk(d[3], d[i] / 6, 2);
			chk(d[4], d[i] / 24, 2);
		end
		wr(8'h04, 8'h00);
		wr(8'h0b, 8'h80);
		wr(8'h0c, 8'h81);
		meas(3000);
		chk(d[3], d[0] / 128, 2);
		wr(8'h0b, 8'h81);
		wr(8'h0c, 8'h82);
		wr(8'h1b, 8'h08);
		wr(8'h1d, 8'h01);
		wr(8'h1e, 8'h04);
		chk(bclk_oe_n, 1'b0, 0);
		meas(1600);
		chk(d[5], d[0] / 8, 2);
		wr(8'h1d, 8'h00);
		meas(1600);
		chk(d[5], d[0] / 4, 2);
		wr(8'h1b, 8'h00);
		wr(8'h1a, 8'h82);
		for (i = 0; i < 7; i++) begin
			wr(8'h19, i[7:0]);
			meas(1200);
			ge = '{d[0], d[1], d[2], 0, d[0], d[0] / 2, 0};
			chk(d[6], ge[i] / 2, 2);
		end
		wr(8'h1a, 8'h02);
		@(negedge clk);
		chk({bclk_oe_n, gp_oe_n}, 2'b11, 0);
		// PLL is enabled before it becomes the reference, as the far side must do
		wr(8'h0b, 8'h81);
		wr(8'h0c, 8'h81);
		wr(8'h06, 8'h01);
		wr(8'h07, 8'h00);
		wr(8'h08, 8'h00);
		wr(8'h05, 8'ha1);
		wr(8'h04, 8'h03);
		meas(800);
		chk(d[3], pexp(d[0], 1, 1, 0, 2), 3);
		wr(8'h07, 8'h13);
		meas(800);
		chk(d[3], pexp(d[0], 1, 1, 0, 2), 3);
		wr(8'h08, 8'h88);
		meas(800);
		chk(d[3], pexp(d[0], 1, 1, 5000, 2), 3);
		wr(8'h05, 8'ha2);
		meas(800);
		chk(d[3], pexp(d[0], 2, 1, 5000, 2), 3);
		wr(8'h05, 8'h22);
		meas(20);
		meas(800);
		chk(d[3], 0, 0);
		wr(8'h05, 8'ha1);
		wr(8'h1b, 8'h08);
		wr(8'h01, 8'h01);
		rd(8'h05, 8'h11);
		dflt();
		chk(bclk_oe_n, 1'b1, 0);
		meas(400);
		chk(d[3], 0, 0);
		wr(8'h3f, 8'hc0);
		meas(50);
		rd(8'h25, 8'h00);
		wr(8'h0b, 8'h81);
		wr(8'h0c, 8'h82);
		meas(50);
		rd(8'h25, 8'h88);
		wr(8'h3f, 8'h00);
		wr(8'h0c, 8'h02);
		meas(200);
		rd(8'h25, 8'h88);
		wr(8'h0c, 8'h82);
		meas(200);
		rd(8'h25, 8'h00);
		results();
	end
endmodule // acp_clock_tree_test
